// file: shared/pram_pkg.sv
// Constants, types and decode helpers of the paged register access manager.
// Assumes one clock; both masters and all sub-modules share it.
// Behaviour
// - Registers reachable by both the on-chip controller and the serial host.
// - Host-only mode: host reaches everything, all interrupts go to its pin.
// - Both masters may access at once; hardware arbitration resolves conflicts.
// - Each interrupt source is routed to either the controller or the host.
// - All registers live in one shared space of 1024 byte locations.
// - Controller sees the space as 1024 consecutive addresses from 0xA000.
// - Host sees four 256-byte pages; offsets 0 to 15 alias global registers.
// - Register address is module base plus offset; modules are contiguous.
// - Global group is 16 bytes at offset 0x00 of every page.
// - Access manager block: 16 bytes, page 0 offset 0x10.
// - Power controller block: 32 bytes, page 0 offset 0x20.
// - Linear regulators at 0x60, real-time clock at 0x40, 32 bytes each.
// - Switching regulators block: 16 bytes, page 0 offset 0x80.
// - Charger at 0x90, timers at 0xA0, reserved 16 bytes at 0xB0.
// - Touch and converter block: 64 bytes, page 0 offset 0xC0.
// - Audio block: 240 bytes on page 1.
// - Speaker digital block: 240 bytes on page 2; page 3 reserved.
// - Byte registers, one address each; wider ones span consecutive bytes.
// - Write-one-clear status reads current state, clears bits written one.
package pram_pkg;

  localparam int          SPACE_SIZE   = 1024;
  localparam int          PAGE_SIZE    = 256;
  localparam int          GLOBAL_SIZE  = 16;
  localparam logic [15:0] MCU_BASE     = 16'ha000;
  localparam int          NUM_IRQ      = 8;
  localparam int          NUM_EXT      = 10;

  // Module bases within page 0; each size runs to the next base
  localparam logic [7:0] BASE_ACCESS   = 8'h10;
  localparam logic [7:0] BASE_POWER    = 8'h20;
  localparam logic [7:0] BASE_RTC      = 8'h40;
  localparam logic [7:0] BASE_LINEAR   = 8'h60;
  localparam logic [7:0] BASE_SWITCH   = 8'h80;
  localparam logic [7:0] BASE_CHARGER  = 8'h90;
  localparam logic [7:0] BASE_TIMERS   = 8'ha0;
  localparam logic [7:0] BASE_RSVD0    = 8'hb0;
  localparam logic [7:0] BASE_TOUCH    = 8'hc0;
  localparam logic [7:0] BASE_PAGED    = 8'h00;

  // Global register indices held by the access manager itself
  localparam logic [3:0] IDX_IRQ_STAT  = 4'h0;
  localparam logic [3:0] IDX_IRQ_ROUTE = 4'h1;
  localparam logic [3:0] IDX_ARB_STAT  = 4'h2;
  localparam logic [7:0] RST_BYTE      = 8'h00;

  typedef enum logic [3:0] {
    M_GLOBAL, M_ACCESS_MANAGER, M_POWER_CONTROLLER, M_REAL_TIME_CLK,
    M_LINEAR_REG, M_SWITCHING_REGULATORS, M_CHARGER, M_GENERAL_TIMERS,
    M_TOUCH_CONVERTER_BLOCK, M_AUDIO, M_SPEAKER_AMP_DIGITAL, M_RESERVED
  } pram_mod_t;

  typedef struct packed {
    pram_mod_t  mod;
    logic [7:0] offset;
  } pram_dec_t;

  typedef struct packed {
    logic       we;
    logic [1:0] page;
    logic [7:0] off;
    logic [7:0] wdata;
  } pram_hreq_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pram_mreq_t;

  typedef struct packed {
    logic       req;
    logic       we;
    logic [9:0] addr;
    logic [7:0] offset;
    logic [7:0] wdata;
  } pram_bus_t;

  // Space address to module and offset within it
  function automatic pram_dec_t pram_decode(input logic [9:0] a);
    pram_dec_t d;
    logic [7:0] o;
    o = a[7:0];
    d.mod = M_RESERVED;
    d.offset = o;
    if (o < 8'(GLOBAL_SIZE))
      d.mod = M_GLOBAL;
    else if (a[9:8] == 2'd1)
      d.mod = M_AUDIO;
    else if (a[9:8] == 2'd2)
      d.mod = M_SPEAKER_AMP_DIGITAL;
    else if (a[9:8] == 2'd0)
    begin
      if (o >= BASE_TOUCH)
        begin d.mod = M_TOUCH_CONVERTER_BLOCK; d.offset = o - BASE_TOUCH; end
      else if (o >= BASE_RSVD0)
        begin d.mod = M_RESERVED; d.offset = o - BASE_RSVD0; end
      else if (o >= BASE_TIMERS)
        begin d.mod = M_GENERAL_TIMERS; d.offset = o - BASE_TIMERS; end
      else if (o >= BASE_CHARGER)
        begin d.mod = M_CHARGER; d.offset = o - BASE_CHARGER; end
      else if (o >= BASE_SWITCH)
        begin d.mod = M_SWITCHING_REGULATORS; d.offset = o - BASE_SWITCH; end
      else if (o >= BASE_LINEAR)
        begin d.mod = M_LINEAR_REG; d.offset = o - BASE_LINEAR; end
      else if (o >= BASE_RTC)
        begin d.mod = M_REAL_TIME_CLK; d.offset = o - BASE_RTC; end
      else if (o >= BASE_POWER)
        begin d.mod = M_POWER_CONTROLLER; d.offset = o - BASE_POWER; end
      else
        begin d.mod = M_ACCESS_MANAGER; d.offset = o - BASE_ACCESS; end
    end
    return d;
  endfunction

  // One-hot select of an external module; global and reserved give none
  function automatic logic [NUM_EXT-1:0] pram_onehot(input pram_mod_t m);
    logic [NUM_EXT-1:0] s;
    s = '0;
    if (m != M_GLOBAL && m != M_RESERVED)
      s[4'(m) - 4'd1] = 1'b1;
    return s;
  endfunction

endpackage

// file: hw/pram_gmem.sv
// Small byte memory for the plain global registers.
// Assumes one clock; read data come out of a register one edge later.
`timescale 1ns/1ps
`default_nettype none
module pram_gmem #(
  parameter int W  = 8,
  parameter int D  = 16,
  parameter int AW = 4
) (
  input  wire logic          clk_in,     // System clock
  input  wire logic          rst_in,     // Sync reset, high
  input  wire logic          wr_en_in,   // Write strobe
  input  wire logic [AW-1:0] wr_addr_in, // Write index
  input  wire logic [W-1:0]  wr_data_in, // Write byte
  input  wire logic          rd_en_in,   // Read strobe
  input  wire logic [AW-1:0] rd_addr_in, // Read index
  output var  logic [W-1:0]  rd_data_out // Registered read byte
);
  logic [W-1:0] mem_q [D];

  // Array has no reset; contents are undefined until written
  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
      mem_q[wr_addr_in] <= wr_data_in;
  end

  // Registered read port
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rd_data_out <= '0;
    else if (rd_en_in)
      rd_data_out <= mem_q[rd_addr_in];
  end
endmodule
`default_nettype wire

// file: hw/pram_top.sv
// Access manager: arbitrates host and controller byte accesses onto the
// shared register space and routes interrupt sources to either master.
// Assumes both request ports and the sub-module bus run on clk_in and
// that sub-modules answer a read combinationally while bus req is high.
`timescale 1ns/1ps
`default_nettype none
module pram_top
  import pram_pkg::*;
#(
  parameter int N_IRQ = pram_pkg::NUM_IRQ
) (
  input  wire logic                     clk_in,        // 50 MHz clock
  input  wire logic                     rst_in,        // Sync reset, high
  input  wire logic                     host_valid_in, // Host request
  input  wire pram_pkg::pram_hreq_t     host_req_in,   // Host page access
  output var  logic                     host_ack_out,  // Host done pulse
  output var  logic [7:0]               host_rdata_out,// Host read byte
  input  wire logic                     mcu_valid_in,  // Controller request
  input  wire pram_pkg::pram_mreq_t     mcu_req_in,    // Controller access
  output var  logic                     mcu_ack_out,   // Controller done
  output var  logic [7:0]               mcu_rdata_out, // Controller byte
  input  wire logic                     mcu_off_in,    // Controller gated
  output var  pram_pkg::pram_bus_t      bus_out,       // Sub-module bus
  output var  logic [NUM_EXT-1:0]       bus_sel_out,   // Module select
  input  wire logic [7:0]               bus_rdata_in,  // Sub-module byte
  input  wire logic [N_IRQ-1:0]         irq_src_in,    // Event pulses
  output var  logic                     host_irq_out,  // Host irq pin
  output var  logic                     mcu_irq_out    // Controller irq
);

  typedef enum logic [1:0] {ST_IDLE, ST_BUS, ST_DONE} pram_state_t;

  pram_state_t      state_q;
  logic             prio_host_q;
  logic             cur_host_q;
  logic             cur_ok_q;
  logic             cur_we_q;
  logic [9:0]       cur_addr_q;
  logic [7:0]       cur_wdata_q;
  pram_dec_t        cur_dec_q;
  logic [N_IRQ-1:0] stat_q;
  logic [N_IRQ-1:0] route_q;
  logic             last_host_q;

  logic             h_want;
  logic             m_want;
  logic             grant_h;
  logic             grant_m;
  logic [9:0]       h_addr;
  logic [9:0]       m_addr;
  logic             m_in_range;
  logic [9:0]       g_addr;
  logic             g_ok;
  pram_dec_t        g_dec;
  logic             glb_wr;
  logic [N_IRQ-1:0] stat_clr;
  logic [N_IRQ-1:0] eff_route;
  logic [7:0]       mem_rdata;
  logic [7:0]       rd_mux;
  logic             plain_glb;

  // Host page plus offset forms the shared space address
  assign h_addr = {host_req_in.page, host_req_in.off};
  // Controller window is 1024 bytes aligned at its base
  assign m_in_range = (mcu_req_in.addr[15:10] == MCU_BASE[15:10]);
  assign m_addr     = mcu_req_in.addr[9:0];

  // Gated controller cannot request; host then owns the space alone
  assign h_want = host_valid_in;
  assign m_want = mcu_valid_in & ~mcu_off_in;

  // Alternating priority so neither master starves the other
  always_comb
  begin
    grant_h = 1'b0;
    grant_m = 1'b0;
    if (state_q == ST_IDLE)
    begin
      if (h_want && (!m_want || prio_host_q))
        grant_h = 1'b1;
      else if (m_want)
        grant_m = 1'b1;
    end
  end

  // Address of the access being granted this cycle
  always_comb
  begin
    g_addr = grant_h ? h_addr : m_addr;
    g_ok   = grant_h | m_in_range;
    g_dec  = pram_decode(g_addr);
  end

  // Access sequence: one byte, granted, on the bus, answered
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      state_q <= ST_IDLE;
    else
    begin
      unique case (state_q)
        ST_IDLE: if (grant_h || grant_m) state_q <= ST_BUS;
        ST_BUS:  state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
      endcase
    end
  end

  // Priority flips to the master that lost the last grant
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      prio_host_q <= 1'b1;
      last_host_q <= 1'b0;
    end
    else if (grant_h || grant_m)
    begin
      prio_host_q <= grant_m;
      last_host_q <= grant_h;
    end
  end

  // Latch the granted access; it is held until its answer
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cur_host_q  <= 1'b0;
      cur_ok_q    <= 1'b0;
      cur_we_q    <= 1'b0;
      cur_addr_q  <= '0;
      cur_wdata_q <= '0;
      cur_dec_q   <= '{mod: M_RESERVED, offset: 8'h00};
    end
    else if (grant_h || grant_m)
    begin
      cur_host_q  <= grant_h;
      cur_ok_q    <= g_ok;
      cur_we_q    <= grant_h ? host_req_in.we : mcu_req_in.we;
      cur_wdata_q <= grant_h ? host_req_in.wdata : mcu_req_in.wdata;
      cur_addr_q  <= g_addr;
      cur_dec_q   <= g_dec;
    end
  end

  // Sub-module bus: one cycle strobe, base-relative offset
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      bus_out     <= '0;
      bus_sel_out <= '0;
    end
    else if (grant_h || grant_m)
    begin
      bus_out.req    <= g_ok && pram_onehot(g_dec.mod) != '0;
      bus_out.we     <= grant_h ? host_req_in.we : mcu_req_in.we;
      bus_out.addr   <= g_addr;
      bus_out.offset <= g_dec.offset;
      bus_out.wdata  <= grant_h ? host_req_in.wdata : mcu_req_in.wdata;
      bus_sel_out    <= g_ok ? pram_onehot(g_dec.mod) : '0;
    end
    else
    begin
      bus_out.req <= 1'b0;
      bus_sel_out <= '0;
    end
  end

  // Global group aliases at the bottom of every page
  assign plain_glb = cur_ok_q && cur_dec_q.mod == M_GLOBAL;
  assign glb_wr    = state_q == ST_BUS && plain_glb && cur_we_q;

  pram_gmem #(
    .W  (8),
    .D  (GLOBAL_SIZE),
    .AW (4)
  ) u_gmem (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .wr_en_in    (glb_wr && cur_addr_q[3:0] > IDX_ARB_STAT),
    .wr_addr_in  (cur_addr_q[3:0]),
    .wr_data_in  (cur_wdata_q),
    .rd_en_in    (grant_h || grant_m),
    .rd_addr_in  (g_addr[3:0]),
    .rd_data_out (mem_rdata)
  );

  // Status bits clear where written one; a new event wins over the clear
  always_comb
  begin
    stat_clr = '0;
    if (glb_wr && cur_addr_q[3:0] == IDX_IRQ_STAT)
      stat_clr = cur_wdata_q[N_IRQ-1:0];
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      stat_q <= '0;
    else
      stat_q <= (stat_q & ~stat_clr) | irq_src_in;
  end

  // Route byte: one selects the host pin, zero the controller
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      route_q <= '0;
    else if (glb_wr && cur_addr_q[3:0] == IDX_IRQ_ROUTE)
      route_q <= cur_wdata_q[N_IRQ-1:0];
  end

  // With the controller gated, every source falls to the host pin
  assign eff_route = route_q | {N_IRQ{mcu_off_in}};

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      host_irq_out <= 1'b0;
      mcu_irq_out  <= 1'b0;
    end
    else
    begin
      host_irq_out <= |(stat_q & eff_route);
      mcu_irq_out  <= |(stat_q & ~eff_route);
    end
  end

  // Read source for the access on the bus
  always_comb
  begin
    rd_mux = RST_BYTE;
    if (!cur_ok_q || cur_dec_q.mod == M_RESERVED)
      rd_mux = RST_BYTE;
    else if (plain_glb)
    begin
      unique case (cur_addr_q[3:0])
        IDX_IRQ_STAT:  rd_mux = 8'(stat_q);
        IDX_IRQ_ROUTE: rd_mux = 8'(route_q);
        IDX_ARB_STAT:  rd_mux = {6'h00, last_host_q, mcu_off_in};
        default:       rd_mux = mem_rdata;
      endcase
    end
    else
      rd_mux = bus_rdata_in;
  end

  // Answer goes only to the master that owned the access
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      host_ack_out   <= 1'b0;
      mcu_ack_out    <= 1'b0;
      host_rdata_out <= RST_BYTE;
      mcu_rdata_out  <= RST_BYTE;
    end
    else
    begin
      host_ack_out <= state_q == ST_BUS && cur_host_q;
      mcu_ack_out  <= state_q == ST_BUS && !cur_host_q;
      if (state_q == ST_BUS && cur_host_q)
        host_rdata_out <= cur_we_q ? RST_BYTE : rd_mux;
      if (state_q == ST_BUS && !cur_host_q)
        mcu_rdata_out <= cur_we_q ? RST_BYTE : rd_mux;
    end
  end

  // Checks on the arbitration, decode and interrupt paths
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  AST_ACK_EXCL: assert property (
    !(host_ack_out && mcu_ack_out))
    else $error("both masters answered at once");

  AST_HOST_LAT: assert property (
    grant_h |-> ##1 !mcu_ack_out ##1 host_ack_out)
    else $error("host access not answered two cycles after grant");

  AST_MCU_LAT: assert property (
    grant_m |-> ##2 mcu_ack_out ##1 !mcu_ack_out)
    else $error("controller answer late or not a pulse");

  AST_OFF_BLOCK: assert property (
    mcu_off_in |-> !grant_m)
    else $error("gated controller was granted");

  AST_FAIR: assert property (
    (grant_h && m_want) |=> !prio_host_q)
    else $error("host kept priority over a waiting controller");

  AST_ALIAS: assert property (
    (grant_h && host_req_in.off < 8'(GLOBAL_SIZE)) |=>
      cur_dec_q.mod == M_GLOBAL && !bus_out.req)
    else $error("page offset below 16 did not hit globals");

  AST_MCU_MAP: assert property (
    (grant_m && m_in_range) |=> bus_out.addr == $past(m_addr))
    else $error("controller address not mapped from its base");

  AST_BUS_PULSE: assert property (
    bus_out.req |=> (!bus_out.req) [*2])
    else $error("bus strobe longer than one access");

  AST_IRQ_SET: assert property (
    irq_src_in[0] |=> stat_q[0])
    else $error("event lost against a clear");

  AST_IRQ_HOST: assert property (
    (stat_q[0] && eff_route[0]) |=> host_irq_out)
    else $error("host pin missed a routed source");

  AST_MCU_IRQ: assert property (
    (stat_q[0] && !eff_route[0]) |=> mcu_irq_out)
    else $error("controller line missed a routed source");

  AST_STAT_CLR: assert property (
    (stat_clr[0] && !irq_src_in[0]) |=> !stat_q[0])
    else $error("status bit not cleared by a one");

  AST_GATED_HOST: assert property (
    (mcu_off_in && stat_q != '0) |=> (host_irq_out && !mcu_irq_out))
    else $error("gated controller still got an interrupt");

  AST_RSVD_QUIET: assert property (
    ((grant_h || grant_m) && pram_onehot(g_dec.mod) == '0) |=>
      (!bus_out.req && bus_sel_out == '0))
    else $error("global or reserved access reached the bus");

  COV_BOTH: cover property (h_want && m_want && state_q == ST_IDLE);
  COV_HOST_WR: cover property (grant_h && host_req_in.we);
  COV_EXT_RD: cover property (bus_out.req && !bus_out.we);
  COV_CLR: cover property (stat_clr[0] && irq_src_in[0]);

endmodule
`default_nettype wire

// file: testbench/pram_sub_model.sv
// Stand-in for the sub-modules behind the register bus.
// Assumes one-cycle strobes with a one-hot select, all on clk_in.
`timescale 1ns/1ps
`default_nettype none
module pram_sub_model (
  input  wire logic                         clk_in,   // System clock
  input  wire pram_pkg::pram_bus_t          bus_in,   // Manager strobe
  input  wire logic [pram_pkg::NUM_EXT-1:0] sel_in,   // Module select
  output var  logic [7:0]                   rdata_out // Read byte
);
  import pram_pkg::*;
  logic [7:0] mem [SPACE_SIZE];
  logic [7:0] last_q = 8'h00;

  // Known pattern so the bench can predict every read
  initial
    for (int i = 0; i < SPACE_SIZE; i++)
      mem[i] = 8'(i) ^ 8'ha5;

  // One byte per address; wide registers are byte sequences
  always @(posedge clk_in)
    if (bus_in.req && bus_in.we && |sel_in)
      mem[bus_in.addr] <= bus_in.wdata;

  // Outside a strobe the data is not held, so stale reads show up
  always @(posedge clk_in)
    last_q <= rdata_out;
  assign rdata_out = bus_in.req ? mem[bus_in.addr] : ~last_q;
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the paged register access manager.
// Assumes the sub-module model answers bus reads combinationally.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pram_pkg::*;
  logic               clk_in;
  logic               rst_in;
  logic               host_valid;
  logic               mcu_valid;
  logic               mcu_off;
  pram_hreq_t         host_req;
  pram_mreq_t         mcu_req;
  logic               host_ack;
  logic               mcu_ack;
  logic [7:0]         host_rdata;
  logic [7:0]         mcu_rdata;
  pram_bus_t          bus_out;
  logic [NUM_EXT-1:0] bus_sel;
  logic [7:0]         bus_rdata;
  logic [7:0]         irq_src;
  logic               host_irq;
  logic               mcu_irq;
  int                 failures = 0;
  int                 checked = 0;
  int                 strobes = 0;
  pram_bus_t          last_bus;
  logic [NUM_EXT-1:0] last_sel;

  pram_top u_dut (
    .clk_in(clk_in), .rst_in(rst_in),
    .host_valid_in(host_valid), .host_req_in(host_req),
    .host_ack_out(host_ack), .host_rdata_out(host_rdata),
    .mcu_valid_in(mcu_valid), .mcu_req_in(mcu_req),
    .mcu_ack_out(mcu_ack), .mcu_rdata_out(mcu_rdata),
    .mcu_off_in(mcu_off), .bus_out(bus_out), .bus_sel_out(bus_sel),
    .bus_rdata_in(bus_rdata), .irq_src_in(irq_src),
    .host_irq_out(host_irq), .mcu_irq_out(mcu_irq)
  );
  pram_sub_model u_sub (
    .clk_in(clk_in), .bus_in(bus_out), .sel_in(bus_sel),
    .rdata_out(bus_rdata)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Bus strobe log; acks of both masters must never coincide
  always @(posedge clk_in)
  begin
    if (bus_out.req === 1'b1)
    begin
      strobes++;
      last_bus = bus_out;
      last_sel = bus_sel;
    end
    if (host_ack === 1'b1 && mcu_ack === 1'b1)
      chk("ack overlap", 16'h0, 16'h1);
  end

  // One byte access; host uses a[9:8] as page, a[7:0] as offset
  task automatic acc(input bit m, input logic we, input logic [15:0] a,
                     input logic [7:0] wd, output logic [7:0] rd,
                     output bit ok);
    ok = 1'b0;
    @(posedge clk_in);
    if (m)
    begin
      mcu_req <= '{we: we, addr: a, wdata: wd};
      mcu_valid <= 1'b1;
    end
    else
    begin
      host_req <= '{we: we, page: a[9:8], off: a[7:0], wdata: wd};
      host_valid <= 1'b1;
    end
    for (int i = 0; i < 12 && !ok; i++)
    begin
      @(posedge clk_in);
      ok = m ? (mcu_ack === 1'b1) : (host_ack === 1'b1);
    end
    rd = m ? mcu_rdata : host_rdata;
    if (m)
      mcu_valid <= 1'b0;
    else
      host_valid <= 1'b0;
  endtask

  task automatic xfer(input bit m, input logic we, input logic [15:0] a,
                      input logic [7:0] wd, input logic [7:0] exp);
    logic [7:0] rd;
    bit         ok;
    acc(m, we, a, wd, rd, ok);
    chk("ack", 16'h1, 16'(ok));
    if (!we)
      chk("rdata", 16'(exp), 16'(rd));
  endtask

  task automatic pulse(input logic [7:0] v);
    @(posedge clk_in);
    irq_src <= v;
    @(posedge clk_in);
    irq_src <= 8'h00;
    repeat (3) @(posedge clk_in);
  endtask

  // A byte in every module, from both masters, lands on its own select
  task automatic t_decode;
    logic [9:0] ta [12] = '{10'h010, 10'h022, 10'h045, 10'h06f, 10'h080,
      10'h09f, 10'h0a3, 10'h0c0, 10'h0ff, 10'h110, 10'h2ef, 10'h1f0};
    logic [7:0] tb_base [12] = '{8'h10, 8'h20, 8'h40, 8'h60, 8'h80,
      8'h90, 8'ha0, 8'hc0, 8'hc0, 8'h00, 8'h00, 8'h00};
    int         ts [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 7, 8, 9, 8};
    int         n;
    logic [15:0] a;
    for (int m = 0; m < 2; m++)
      for (int i = 0; i < 12; i++)
      begin
        n = strobes;
        a = m ? (MCU_BASE | 16'(ta[i])) : 16'(ta[i]);
        xfer(m[0], 1'b0, a, 8'h00, ta[i][7:0] ^ 8'ha5);
        chk("strobes", 16'(n + 1), 16'(strobes));
        chk("sel", 16'h1 << ts[i], 16'(last_sel));
        chk("addr", 16'(ta[i]), 16'(last_bus.addr));
        chk("offset", 16'(ta[i][7:0] - tb_base[i]),
            16'(last_bus.offset));
      end
  endtask

  // Writes and a two-byte register reach the same places for both
  task automatic t_write;
    xfer(0, 1'b1, 16'h0025, 8'h3c, 8'h00);
    chk("bus we", 16'h1, 16'(last_bus.we));
    chk("bus wdata", 16'h3c, 16'(last_bus.wdata));
    xfer(1, 1'b0, 16'ha025, 8'h00, 8'h3c);
    xfer(1, 1'b1, 16'ha0c2, 8'h12, 8'h00);
    xfer(1, 1'b1, 16'ha0c3, 8'h34, 8'h00);
    xfer(0, 1'b0, 16'h00c2, 8'h00, 8'h12);
    xfer(0, 1'b0, 16'h00c3, 8'h00, 8'h34);
  endtask

  // Reserved bytes are only read; unmapped places are also written
  task automatic t_reserved;
    bit          tm [6] = '{0, 0, 1, 1, 1, 1};
    logic [15:0] ta [6] = '{16'h00b4, 16'h0340, 16'ha0bf, 16'ha3f0,
      16'h9fff, 16'ha400};
    int          n;
    for (int i = 0; i < 6; i++)
    begin
      n = strobes;
      xfer(tm[i], i >= 4, ta[i], 8'hff, 8'h00);
      xfer(tm[i], 1'b0, ta[i], 8'h00, 8'h00);
      chk("no strobe", 16'(n), 16'(strobes));
    end
  endtask

  // Offsets 0..15 are one shared set on every page, never on the bus
  task automatic t_global;
    int n;
    n = strobes;
    xfer(0, 1'b1, 16'h0105, 8'h5a, 8'h00);
    xfer(1, 1'b0, 16'ha305, 8'h00, 8'h5a);
    xfer(0, 1'b0, 16'h0205, 8'h00, 8'h5a);
    xfer(0, 1'b1, 16'h0002, 8'hff, 8'h00);
    xfer(0, 1'b0, 16'h0302, 8'h00, 8'h02);
    chk("no strobe", 16'(n), 16'(strobes));
  endtask

  // Source 0 to host, source 1 to controller, then cleared by ones
  task automatic t_irq;
    xfer(0, 1'b1, 16'h0001, 8'h01, 8'h00);
    pulse(8'h01);
    chk("host irq", 16'h1, 16'(host_irq));
    chk("mcu irq", 16'h0, 16'(mcu_irq));
    pulse(8'h02);
    chk("mcu irq", 16'h1, 16'(mcu_irq));
    xfer(1, 1'b0, 16'ha000, 8'h00, 8'h03);
    xfer(1, 1'b1, 16'ha000, 8'h01, 8'h00);
    repeat (3) @(posedge clk_in);
    chk("host irq", 16'h0, 16'(host_irq));
    chk("mcu irq", 16'h1, 16'(mcu_irq));
    xfer(0, 1'b0, 16'h0100, 8'h00, 8'h02);
    xfer(0, 1'b1, 16'h0200, 8'h02, 8'h00);
    @(posedge clk_in);
    chk("mcu irq", 16'h0, 16'(mcu_irq));
  endtask

  // Both masters at once: each served whole, one strobe each
  task automatic t_arb;
    int n;
    n = strobes;
    fork
      xfer(0, 1'b1, 16'h0030, 8'h11, 8'h00);
      xfer(1, 1'b1, 16'ha031, 8'h22, 8'h00);
    join
    fork
      xfer(0, 1'b0, 16'h0031, 8'h00, 8'h22);
      xfer(1, 1'b0, 16'ha030, 8'h00, 8'h11);
    join
    chk("strobes", 16'(n + 4), 16'(strobes));
  endtask

  // Gated controller: ignored, and its interrupts go to the host pin
  task automatic t_gated;
    logic [7:0] rd;
    bit         ok;
    @(posedge clk_in);
    mcu_off <= 1'b1;
    acc(1, 1'b0, 16'ha020, 8'h00, rd, ok);
    chk("gated ack", 16'h0, 16'(ok));
    xfer(0, 1'b0, 16'h0002, 8'h00, 8'h03);
    pulse(8'h02);
    chk("host irq", 16'h1, 16'(host_irq));
    chk("mcu irq", 16'h0, 16'(mcu_irq));
    xfer(0, 1'b1, 16'h0000, 8'h02, 8'h00);
    @(posedge clk_in);
    mcu_off <= 1'b0;
  endtask

  initial
  begin
    rst_in = 1'b1;
    host_valid = 1'b0;
    mcu_valid = 1'b0;
    mcu_off = 1'b0;
    host_req = '0;
    mcu_req = '0;
    irq_src = 8'h00;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    chk("reset bus", 16'h0, 16'({bus_out.req, bus_sel}));
    chk("reset irq", 16'h0, 16'({host_irq, mcu_irq}));
    t_decode;
    t_write;
    t_reserved;
    t_global;
    t_irq;
    t_arb;
    t_gated;
    finish_test;
  end

  // Cuts a hang well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_in);
    failures++;
    finish_test;
  end
endmodule
`default_nettype wire
